/* File: src/shadow_cfg_pkg.sv */
// constants for the shadow port readback and serial interrupt configuration group
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package shadow_cfg_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SELECT = 8'h6E;
  localparam logic [7:0] IDX_DATA   = 8'h6F;
  localparam logic [7:0] IDX_SERIRQ = 8'h70;
  localparam int         IDX_LSB    = 2;

  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] SERIRQ_RESET = 8'h12;

  // select register fields
  localparam int DEV_MSB  = 7;
  localparam int DEV_LSB  = 5;
  localparam int PORT_MSB = 4;
  localparam int PORT_LSB = 0;

  // peripheral codes
  localparam logic [2:0] DEV_TIMER     = 3'h1;
  localparam logic [2:0] DEV_INT_MAST  = 3'h2;
  localparam logic [2:0] DEV_INT_SLAVE = 3'h3;
  localparam logic [2:0] DEV_DMA_MAST  = 3'h4;
  localparam logic [2:0] DEV_DMA_SLAVE = 3'h5;

  // last valid port code per peripheral, plus the reserved interrupt code and dma mode/mask codes
  localparam logic [4:0] LAST_TIMER     = 5'h05;
  localparam logic [4:0] LAST_INT       = 5'h06;
  localparam logic [4:0] INT_RESERVED   = 5'h05;
  localparam logic [4:0] LAST_DMA_MAST  = 5'h13;
  localparam logic [4:0] LAST_DMA_SLAVE = 5'h14;
  localparam logic [4:0] DMA_MODE_LAST  = 5'h03;
  localparam logic [4:0] DMA_REQ_MASK   = 5'h04;

  // serial interrupt control fields
  localparam int SER_EN_BIT    = 7;
  localparam int SER_STOP_BIT  = 6;
  localparam int SER_FRM_MSB   = 5;
  localparam int SER_FRM_LSB   = 2;
  localparam int SER_START_MSB = 1;
  localparam int SER_START_LSB = 0;

  // widths in bus clocks, frame base count
  localparam logic [1:0] STOP_QUIET  = 2'h2;
  localparam logic [1:0] STOP_CONT   = 2'h3;
  localparam logic [5:0] FRAME_BASE  = 6'h11;
  localparam logic [3:0] START_W4    = 4'h4;
  localparam logic [3:0] START_W6    = 4'h6;
  localparam logic [3:0] START_W8    = 4'h8;
  localparam logic [1:0] START_C4    = 2'h0;
  localparam logic [1:0] START_C6    = 2'h1;
  localparam logic [1:0] START_C8    = 2'h2;

endpackage : shadow_cfg_pkg

/* File: src/shadow_port_readback_and_serirq_cfg.sv */
// apb register group: shadowed legacy port readback and serial interrupt setup
`timescale 1ns/10ps
module shadow_port_readback_and_serirq_cfg #(
  parameter int NUM_DEV    = 5,
  parameter int PORT_DEPTH = 21
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // port writes seen by the legacy peripherals
  input  wire logic        cap_valid_i,
  input  wire logic [2:0]  cap_dev_i,
  input  wire logic [4:0]  cap_port_i,
  input  wire logic [7:0]  cap_data_i,
  // serial interrupt engine settings
  output logic             serirq_enable_o,
  output logic             serirq_continuous_o,
  output logic [1:0]       serirq_stop_clocks_o,
  output logic [5:0]       serirq_frames_o,
  output logic [3:0]       serirq_start_clocks_o
);

  // --------------------------------------------------------------------------
  // port map decode
  // --------------------------------------------------------------------------
  // true when a peripheral and port code name a shadowed port
  function automatic logic port_ok(input logic [2:0] dev, input logic [4:0] port);
    logic ok;
    ok = 1'b0;
    case (dev)
      shadow_cfg_pkg::DEV_TIMER:
        ok = (port <= shadow_cfg_pkg::LAST_TIMER);
      shadow_cfg_pkg::DEV_INT_MAST,
      shadow_cfg_pkg::DEV_INT_SLAVE:
        ok = (port <= shadow_cfg_pkg::LAST_INT) &&
             (port != shadow_cfg_pkg::INT_RESERVED);
      shadow_cfg_pkg::DEV_DMA_MAST:
        ok = (port <= shadow_cfg_pkg::LAST_DMA_MAST);
      shadow_cfg_pkg::DEV_DMA_SLAVE:
        ok = (port <= shadow_cfg_pkg::LAST_DMA_SLAVE);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : port_ok

  // peripheral code 1..5 onto row 0..4
  function automatic logic [2:0] dev_row(input logic [2:0] dev);
    return dev - shadow_cfg_pkg::DEV_TIMER;
  endfunction : dev_row

  // --------------------------------------------------------------------------
  // shadow store
  // --------------------------------------------------------------------------
  // rows hold mode, request/mask, address and count bytes in port-code order,
  // so a readback is a plain lookup by code
  logic [7:0] shadow_mem      [NUM_DEV][PORT_DEPTH];
  logic [7:0] next_shadow_mem [NUM_DEV][PORT_DEPTH];

  always_comb
  begin
    next_shadow_mem = shadow_mem;
    if (!rst_n_i)
    begin
      for (int d = 0; d < NUM_DEV; d++)
      begin
        for (int p = 0; p < PORT_DEPTH; p++)
        begin
          next_shadow_mem[d][p] = 8'h00;
        end
      end
    end
    else if (cap_valid_i && port_ok(cap_dev_i, cap_port_i))
    begin
      next_shadow_mem[dev_row(cap_dev_i)][cap_port_i] = cap_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    shadow_mem <= next_shadow_mem;
  end

  // --------------------------------------------------------------------------
  // apb register access
  // --------------------------------------------------------------------------
  logic [7:0]  select_reg;
  logic [7:0]  next_select_reg;
  logic [7:0]  serirq_reg;
  logic [7:0]  next_serirq_reg;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  word_idx;
  logic        access;
  logic        hit_select;
  logic        hit_data;
  logic        hit_serirq;
  logic [2:0]  sel_dev;
  logic [4:0]  sel_port;
  logic [7:0]  shadow_byte;

  assign word_idx   = paddr_i[shadow_cfg_pkg::IDX_LSB +: 8];
  // one wait state: the answer flop fires once per access phase
  assign access     = psel_i && penable_i && !pready_o;
  assign hit_select = (word_idx == shadow_cfg_pkg::IDX_SELECT);
  assign hit_data   = (word_idx == shadow_cfg_pkg::IDX_DATA);
  assign hit_serirq = (word_idx == shadow_cfg_pkg::IDX_SERIRQ);
  assign sel_dev    = select_reg[shadow_cfg_pkg::DEV_MSB:shadow_cfg_pkg::DEV_LSB];
  assign sel_port   = select_reg[shadow_cfg_pkg::PORT_MSB:shadow_cfg_pkg::PORT_LSB];

  // reserved codes read back as zero
  always_comb
  begin
    shadow_byte = 8'h00;
    if (port_ok(sel_dev, sel_port))
    begin
      shadow_byte = shadow_mem[dev_row(sel_dev)][sel_port];
    end
  end

  always_comb
  begin
    next_select_reg = select_reg;
    next_serirq_reg = serirq_reg;
    next_prdata     = 32'h0000_0000;
    next_pready     = 1'b0;
    next_pslverr    = 1'b0;
    if (!rst_n_i)
    begin
      next_select_reg = shadow_cfg_pkg::SELECT_RESET;
      next_serirq_reg = shadow_cfg_pkg::SERIRQ_RESET;
    end
    else if (access)
    begin
      next_pready = 1'b1;
      if (pwrite_i)
      begin
        if (hit_select)
        begin
          if (pstrb_i[0])
          begin
            next_select_reg = pwdata_i[7:0];
          end
        end
        else if (hit_serirq)
        begin
          if (pstrb_i[0])
          begin
            next_serirq_reg = pwdata_i[7:0];
          end
        end
        else
        begin
          // data register is read-only; writes there fail like unmapped ones
          next_pslverr = 1'b1;
        end
      end
      else
      begin
        if (hit_select)
        begin
          next_prdata = {24'h00_0000, select_reg};
        end
        else if (hit_data)
        begin
          next_prdata = {24'h00_0000, shadow_byte};
        end
        else if (hit_serirq)
        begin
          next_prdata = {24'h00_0000, serirq_reg};
        end
        else
        begin
          next_pslverr = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    select_reg <= next_select_reg;
    serirq_reg <= next_serirq_reg;
    prdata_o   <= next_prdata;
    pready_o   <= next_pready;
    pslverr_o  <= next_pslverr;
  end

  // --------------------------------------------------------------------------
  // serial interrupt settings decode
  // --------------------------------------------------------------------------
  logic       next_ser_en;
  logic       next_ser_cont;
  logic [1:0] next_ser_stop;
  logic [5:0] next_ser_frames;
  logic [3:0] next_ser_start;
  logic [3:0] frame_field;
  logic [1:0] start_code;

  assign frame_field = next_serirq_reg[shadow_cfg_pkg::SER_FRM_MSB:shadow_cfg_pkg::SER_FRM_LSB];
  assign start_code  =
    next_serirq_reg[shadow_cfg_pkg::SER_START_MSB:shadow_cfg_pkg::SER_START_LSB];

  // decoded from the next register value so the outputs track it the same edge
  always_comb
  begin
    next_ser_en     = next_serirq_reg[shadow_cfg_pkg::SER_EN_BIT];
    next_ser_cont   = next_serirq_reg[shadow_cfg_pkg::SER_STOP_BIT];
    next_ser_stop   = next_ser_cont ? shadow_cfg_pkg::STOP_CONT
                                    : shadow_cfg_pkg::STOP_QUIET;
    next_ser_frames = shadow_cfg_pkg::FRAME_BASE + {2'b00, frame_field};
    case (start_code)
      shadow_cfg_pkg::START_C4: next_ser_start = shadow_cfg_pkg::START_W4;
      shadow_cfg_pkg::START_C6: next_ser_start = shadow_cfg_pkg::START_W6;
      shadow_cfg_pkg::START_C8: next_ser_start = shadow_cfg_pkg::START_W8;
      // reserved code: fall back to the widest pulse rather than a bad width
      default:                  next_ser_start = shadow_cfg_pkg::START_W8;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    serirq_enable_o       <= next_ser_en;
    serirq_continuous_o   <= next_ser_cont;
    serirq_stop_clocks_o  <= next_ser_stop;
    serirq_frames_o       <= next_ser_frames;
    serirq_start_clocks_o <= next_ser_start;
  end

endmodule : shadow_port_readback_and_serirq_cfg

/* File: testbench/shadow_cfg_assertions.sv */
// checker of apb answers and serial interrupt settings
`timescale 1ns/10ps
module shadow_cfg_assertions (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        serirq_enable_o,
  input wire logic        serirq_continuous_o,
  input wire logic [1:0]  serirq_stop_clocks_o,
  input wire logic [5:0]  serirq_frames_o,
  input wire logic [3:0]  serirq_start_clocks_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic tk = psel_i & penable_i & ~pready_o;
  wire logic wc = tk & pwrite_i & pstrb_i[0] & (paddr_i[9:2] == 8'h70);
  ready_pulse_a: assert property (tk |=> pready_o ##1 !pready_o)
    else $error("answer is not one cycle");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  ro_write_a: assert property (tk && pwrite_i && paddr_i[9:2] == 8'h6F |=> pslverr_o)
    else $error("data register write not refused");
  enable_map_a: assert property (wc |=> serirq_enable_o == $past(pwdata_i[7]))
    else $error("enable wrong");
  cont_map_a: assert property (wc |=> serirq_continuous_o == $past(pwdata_i[6]))
    else $error("stop mode wrong");
  stop_width_a: assert property (serirq_stop_clocks_o == (serirq_continuous_o ? 2'h3 : 2'h2))
    else $error("stop width wrong");
  frame_count_a: assert property (wc |=> serirq_frames_o == 6'h11 + $past(pwdata_i[5:2]))
    else $error("frame count wrong");
  start_width_a: assert property (wc && pwdata_i[1:0] != 2'h3
    |=> serirq_start_clocks_o == 4'h4 + {$past(pwdata_i[1:0]), 1'b0}) else $error("start wrong");
  reset_val_a: assert property ($rose(rst_n_i) |-> serirq_frames_o == 6'h15
    && serirq_start_clocks_o == 4'h8 && !serirq_enable_o) else $error("reset settings wrong");
endmodule : shadow_cfg_assertions
bind shadow_port_readback_and_serirq_cfg shadow_cfg_assertions chk_i (.*);

/* File: testbench/legacy_port_model.sv */
// model of the legacy peripherals reporting their port writes
`timescale 1ns/10ps
module legacy_port_model (
  input  wire logic  sys_clk_i,
  output logic       cap_valid_o,
  output logic [2:0] cap_dev_o,
  output logic [4:0] cap_port_o,
  output logic [7:0] cap_data_o
);
  initial
  begin
    cap_valid_o = 1'b0;
    cap_dev_o = 3'h0;
    cap_port_o = 5'h00;
    cap_data_o = 8'h00;
  end
  // byte turns to its inverse after the report so a stale byte is never taken
  task automatic put(input logic [2:0] d, input logic [4:0] p, input logic [7:0] v);
    @(posedge sys_clk_i);
    cap_valid_o <= 1'b1;
    cap_dev_o <= d;
    cap_port_o <= p;
    cap_data_o <= v;
    @(posedge sys_clk_i);
    cap_valid_o <= 1'b0;
    cap_data_o <= ~v;
  endtask : put
endmodule : legacy_port_model

/* File: testbench/test_shadow_port_readback_and_serirq_cfg.sv */
// self-checking bench for the shadow readback and serial interrupt group
`timescale 1ns/10ps
module test_shadow_port_readback_and_serirq_cfg;
  localparam logic [11:0] A_SEL = {2'h0, shadow_cfg_pkg::IDX_SELECT, 2'h0};
  localparam logic [11:0] A_DAT = {2'h0, shadow_cfg_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, shadow_cfg_pkg::IDX_SERIRQ, 2'h0};
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0]  pstrb_i = 4'hF, serirq_start_clocks_o;
  logic        pready_o, pslverr_o, er, cap_valid_i, serirq_enable_o, serirq_continuous_o;
  logic [2:0]  cap_dev_i;
  logic [4:0]  cap_port_i;
  logic [7:0]  cap_data_i, v, c;
  logic [1:0]  serirq_stop_clocks_o;
  logic [5:0]  serirq_frames_o;
  int          fails = 0, checks_done = 0, cyc = 0;
  // valid flag, peripheral code, port code
  logic [8:0]  tbl [16] = '{9'h125, 9'h026, 9'h146, 9'h045, 9'h160, 9'h067, 9'h184, 9'h193,
                            9'h094, 9'h1A3, 9'h1B4, 9'h0B5, 9'h001, 9'h0C1, 9'h0E1, 9'h180};
  logic [7:0]  ctl [3] = '{8'h12, 8'hC0, 8'h3D};
  initial forever #4 sys_clk_i = ~sys_clk_i;
  shadow_port_readback_and_serirq_cfg uut (.*);
  legacy_port_model pm (.sys_clk_i, .cap_valid_o(cap_valid_i), .cap_dev_o(cap_dev_i),
                        .cap_port_o(cap_port_i), .cap_data_o(cap_data_i));
  task automatic finish_test;
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ready, read data and error are taken at the rising edge that samples ready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rdchk(input string n, input logic [11:0] a, input logic [7:0] e, input logic x);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rd);
    chk("error", {31'h0, x}, {31'h0, er});
  endtask : rdchk
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      finish_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rdchk("select", A_SEL, 8'h00, 1'b0);
    rdchk("control", A_CTL, 8'h12, 1'b0);
    foreach (ctl[i])
    begin
      c = ctl[i];
      apb(1'b1, A_CTL, c);
      rdchk("control", A_CTL, c, 1'b0);
      chk("enable", {31'h0, c[7]}, {31'h0, serirq_enable_o});
      chk("stop", c[6] ? 32'h3 : 32'h2, {30'h0, serirq_stop_clocks_o});
      chk("frames", 32'h11 + c[5:2], {26'h0, serirq_frames_o});
      chk("start", 32'h4 + {c[1:0], 1'b0}, {28'h0, serirq_start_clocks_o});
    end
    pstrb_i <= 4'h0;
    apb(1'b1, A_CTL, 8'hFF);
    pstrb_i <= 4'hF;
    rdchk("control", A_CTL, 8'h3D, 1'b0);
    apb(1'b1, A_DAT, 8'h55);
    chk("error", 32'h1, {31'h0, er});
    rdchk("unmapped", 12'h1C4, 8'h00, 1'b1);
    foreach (tbl[i])
    begin
      v = tbl[i][7:0] ^ 8'h5A;
      pm.put(tbl[i][7:5], tbl[i][4:0], v);
      apb(1'b1, A_SEL, tbl[i][7:0]);
      rdchk("shadow", A_DAT, tbl[i][8] ? v : 8'h00, 1'b0);
    end
    finish_test;
  end
endmodule : test_shadow_port_readback_and_serirq_cfg
